// *** rtl/rar_pkg.sv ***
// Summary of operation
// - Two alarms rise when distance below threshold
// - Single-point alarms re-evaluated per new measurement
// - Scanning alarms qualified by distance and zone
// - Scanning alarms change only at sweep end
// - Product query answered with identity text
// - Selector 0 query returns median first distance
// - Selector 1 query returns raw first distance
// - I2C target address defaults to factory value
// - Sync string answered with identity text
// - Same commands accepted on serial or I2C
// - Hysteresis shifts single-point activate and release levels
// - Threshold programmable up to hundred meters
`default_nettype none
package rar_pkg;
  // Distances are in centimetres
  localparam int DIST_CM_W = 32'h11;
  localparam int ANGLE_W_DEF = 32'ha;
  localparam int THRESH_MAX_CM = 32'h2710;
  localparam int HYST_MAX_CM = 32'h3e8;
  localparam int CMD_BUF_DEPTH = 32'h8;
  localparam int ID_MAX = 32'h1e;
  localparam int DIST_REPLY_LAST = 32'he;
  localparam logic [6:0] I2C_ADDR_RST = 7'h66;
  localparam logic [7:0] CH_OPEN = 8'h3c;
  localparam logic [7:0] CH_CLOSE = 8'h3e;
  localparam logic [7:0] CH_QUERY = 8'h3f;
  localparam logic [7:0] CH_SYNC = 8'h55;
  localparam logic [7:0] CH_FQ_1 = 8'h4c;
  localparam logic [7:0] CH_FQ_2 = 8'h44;
  localparam logic [7:0] CH_FQ_3 = 8'h46;
  localparam logic [7:0] CH_TAG_1 = 8'h6c;
  localparam logic [7:0] CH_TAG_2 = 8'h64;
  localparam logic [7:0] CH_TAG_3 = 8'h66;
  localparam logic [7:0] CH_COMMA = 8'h2c;
  localparam logic [7:0] CH_COLON = 8'h3a;
  localparam logic [7:0] CH_DOT = 8'h2e;
  localparam logic [7:0] CH_ZERO = 8'h30;
  localparam logic [7:0] CH_ONE = 8'h31;
  localparam logic [7:0] CH_CR = 8'h0d;
  localparam logic [7:0] CH_LF = 8'h0a;

  typedef enum logic [2:0] {
    RAR_CMD_NONE,
    RAR_CMD_PRODUCT,
    RAR_CMD_SYNC,
    RAR_CMD_FIRST_MED,
    RAR_CMD_FIRST_RAW
  } rar_cmd_t;

  // Decimal digit weights in cm: 1000 m down to 1 cm
  function automatic logic [16:0] rar_weight(input logic [2:0] idx);
    case (idx)
      3'h0: rar_weight = 17'h186a0;
      3'h1: rar_weight = 17'h02710;
      3'h2: rar_weight = 17'h003e8;
      3'h3: rar_weight = 17'h00064;
      3'h4: rar_weight = 17'h0000a;
      default: rar_weight = 17'h00001;
    endcase
  endfunction : rar_weight
endpackage : rar_pkg
`default_nettype wire

// *** rtl/rar_frame.sv ***
`timescale 1ns/1ns
`default_nettype none
module rar_frame import rar_pkg::*; #(
  parameter int DEPTH = CMD_BUF_DEPTH
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic byte_valid,
  input wire logic [7:0] byte_data,
  output logic cmd_valid,
  output rar_cmd_t cmd
);
  if (DEPTH < 6 || DEPTH > 15) begin : g_bad_depth
    $error("rar_frame: DEPTH must be 6 to 15");
  end

  logic [DEPTH-1:0][7:0] chr_ff, nxt_chr;
  logic [3:0] len_ff, nxt_len;
  logic open_ff, nxt_open, over_ff, nxt_over;
  logic cmd_valid_ff, nxt_cmd_valid;
  rar_cmd_t cmd_ff, nxt_cmd;

  function automatic rar_cmd_t rar_classify(input logic [DEPTH-1:0][7:0] b, input logic [3:0] n);
    rar_classify = RAR_CMD_NONE;
    if (n == 4'h1 && b[0] == CH_QUERY) begin
      rar_classify = RAR_CMD_PRODUCT;
    end else if (n == 4'h2 && b[0] == CH_SYNC && b[1] == CH_SYNC) begin
      rar_classify = RAR_CMD_SYNC;
    end else if (n == 4'h6 && b[0] == CH_QUERY && b[1] == CH_FQ_1 && b[2] == CH_FQ_2
        && b[3] == CH_FQ_3 && b[4] == CH_COMMA) begin
      if (b[5] == CH_ZERO) begin
        rar_classify = RAR_CMD_FIRST_MED;
      end else if (b[5] == CH_ONE) begin
        rar_classify = RAR_CMD_FIRST_RAW;
      end
    end
  endfunction : rar_classify

  always_comb begin
    nxt_chr = chr_ff;
    nxt_len = len_ff;
    nxt_open = open_ff;
    nxt_over = over_ff;
    nxt_cmd = RAR_CMD_NONE;
    nxt_cmd_valid = 1'b0;
    if (byte_valid) begin
      if (byte_data == CH_OPEN) begin
        nxt_open = 1'b1;
        nxt_len = 4'h0;
        nxt_over = 1'b0;
      end else if (open_ff && byte_data == CH_CLOSE) begin
        nxt_open = 1'b0;
        nxt_cmd = over_ff ? RAR_CMD_NONE : rar_classify(chr_ff, len_ff);
        nxt_cmd_valid = nxt_cmd != RAR_CMD_NONE;
      end else if (open_ff) begin
        if (len_ff == 4'(DEPTH)) begin
          nxt_over = 1'b1;
        end else begin
          nxt_chr[len_ff] = byte_data;
          nxt_len = len_ff + 4'h1;
        end
      end
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      chr_ff <= '0;
      len_ff <= 4'h0;
      open_ff <= 1'b0;
      over_ff <= 1'b0;
      cmd_ff <= RAR_CMD_NONE;
      cmd_valid_ff <= 1'b0;
    end else begin
      chr_ff <= nxt_chr;
      len_ff <= nxt_len;
      open_ff <= nxt_open;
      over_ff <= nxt_over;
      cmd_ff <= nxt_cmd;
      cmd_valid_ff <= nxt_cmd_valid;
    end
  end

  assign cmd_valid = cmd_valid_ff;
  assign cmd = cmd_ff;

  a_cmd_on_close: assert property (@(posedge clock) disable iff (sys_rst)
    cmd_valid_ff |-> $past(byte_valid && byte_data == CH_CLOSE && open_ff))
    else $error("command issued without closing bracket");
  a_open_no_cmd: assert property (@(posedge clock) disable iff (sys_rst)
    (byte_valid && byte_data == CH_OPEN) |=> !cmd_valid_ff)
    else $error("opening bracket produced a command");
endmodule : rar_frame
`default_nettype wire

// *** rtl/rar_alarm.sv ***
`timescale 1ns/1ns
`default_nettype none
module rar_alarm import rar_pkg::*; #(
  parameter int DIST_W = DIST_CM_W,
  parameter int ANGLE_W = ANGLE_W_DEF
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic meas_valid,
  input wire logic [DIST_W-1:0] meas_dist,
  input wire logic scan_on,
  input wire logic [ANGLE_W-1:0] scan_angle,
  input wire logic sweep_end,
  input wire logic [DIST_W-1:0] thresh,
  input wire logic [DIST_W-1:0] hyst,
  input wire logic [ANGLE_W-1:0] zone_lo,
  input wire logic [ANGLE_W-1:0] zone_hi,
  output logic alarm
);
  if (DIST_W < 14 || ANGLE_W < 1) begin : g_bad_param
    $error("rar_alarm: unsupported parameter value");
  end

  logic alarm_ff, nxt_alarm, armed_ff, nxt_armed, hit, upd;
  logic [DIST_W-1:0] thr, hy, on_lvl;
  logic [DIST_W:0] off_lvl;

  always_comb begin
    thr = (thresh > DIST_W'(THRESH_MAX_CM)) ? DIST_W'(THRESH_MAX_CM) : thresh;
    hy = (hyst > DIST_W'(HYST_MAX_CM)) ? DIST_W'(HYST_MAX_CM) : hyst;
    on_lvl = (thr > hy) ? thr - hy : '0;
    off_lvl = {1'b0, thr} + {1'b0, hy};
    hit = meas_valid && scan_angle >= zone_lo && scan_angle <= zone_hi && meas_dist < thr;
    upd = armed_ff || hit;
    nxt_alarm = alarm_ff;
    nxt_armed = 1'b0;
    if (scan_on) begin
      nxt_armed = sweep_end ? 1'b0 : upd;
      if (sweep_end) begin
        nxt_alarm = upd;
      end
    end else if (meas_valid) begin
      if (!alarm_ff && meas_dist < on_lvl) begin
        nxt_alarm = 1'b1;
      end else if (alarm_ff && {1'b0, meas_dist} >= off_lvl) begin
        nxt_alarm = 1'b0;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      alarm_ff <= 1'b0;
      armed_ff <= 1'b0;
    end else begin
      alarm_ff <= nxt_alarm;
      armed_ff <= nxt_armed;
    end
  end

  assign alarm = alarm_ff;

  a_scan_hold: assert property (@(posedge clock) disable iff (sys_rst)
    (scan_on && !sweep_end) |=> $stable(alarm_ff))
    else $error("scanning alarm changed mid sweep");
  a_sweep_update: assert property (@(posedge clock) disable iff (sys_rst)
    (scan_on && sweep_end) |=> alarm_ff == $past(upd))
    else $error("scanning alarm missed sweep end update");
  a_single_set: assert property (@(posedge clock) disable iff (sys_rst)
    (!scan_on && meas_valid && meas_dist < on_lvl) |=> alarm_ff)
    else $error("alarm did not rise below threshold");
  a_single_clear: assert property (@(posedge clock) disable iff (sys_rst)
    (!scan_on && meas_valid && {1'b0, meas_dist} >= off_lvl) |=> !alarm_ff)
    else $error("alarm did not release above threshold");
endmodule : rar_alarm
`default_nettype wire

// *** rtl/rar_top.sv ***
`timescale 1ns/1ns
`default_nettype none
module rar_top import rar_pkg::*; #(
  parameter int DIST_W = DIST_CM_W,
  parameter int ANGLE_W = ANGLE_W_DEF,
  parameter int ID_LEN = 32'he,
  // Identity text value is arbitrary
  parameter logic [8*ID_MAX-1:0] ID_TEXT = "p:RG01,1.0.0,1"
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic meas_valid,
  input wire logic [DIST_W-1:0] dist_median,
  input wire logic [DIST_W-1:0] dist_raw,
  input wire logic scan_on,
  input wire logic [ANGLE_W-1:0] scan_angle,
  input wire logic sweep_end,
  input wire logic [DIST_W-1:0] alarm_a_thresh,
  input wire logic [DIST_W-1:0] alarm_b_thresh,
  input wire logic [DIST_W-1:0] alarm_hyst,
  input wire logic [ANGLE_W-1:0] zone_a_lo,
  input wire logic [ANGLE_W-1:0] zone_a_hi,
  input wire logic [ANGLE_W-1:0] zone_b_lo,
  input wire logic [ANGLE_W-1:0] zone_b_hi,
  input wire logic ser_rx_valid,
  input wire logic [7:0] ser_rx_data,
  input wire logic i2c_rx_valid,
  input wire logic [7:0] i2c_rx_data,
  input wire logic i2c_addr_wr,
  input wire logic [6:0] i2c_addr_new,
  input wire logic i2c_addr_seen_valid,
  input wire logic [6:0] i2c_addr_seen,
  input wire logic tx_ready,
  output logic alarm_a,
  output logic alarm_b,
  output logic tx_valid,
  output logic [7:0] tx_data,
  output logic tx_to_i2c,
  output logic [6:0] i2c_addr,
  output logic i2c_addr_match
);
  if (DIST_W < 14 || DIST_W > 17 || ID_LEN < 1 || ID_LEN > ID_MAX) begin : g_bad_param
    $error("rar_top: unsupported parameter value");
  end

  typedef enum logic [1:0] {RPL_IDLE, RPL_CONV, RPL_EMIT, RPL_DRAIN} rar_rpl_t;

  // ----------------------------------------------------------------
  // Source arbitration
  // ----------------------------------------------------------------
  logic lock_ff, nxt_lock, src_ff, nxt_src;
  logic rx_src, rx_valid;
  logic [7:0] rx_data;

  // A frame locks to the port that opened it; serial wins a tie
  always_comb begin
    rx_src = lock_ff ? src_ff : !ser_rx_valid;
    rx_valid = rx_src ? i2c_rx_valid : ser_rx_valid;
    rx_data = rx_src ? i2c_rx_data : ser_rx_data;
    nxt_lock = lock_ff;
    nxt_src = src_ff;
    if (rx_valid && rx_data == CH_OPEN) begin
      nxt_lock = 1'b1;
      nxt_src = rx_src;
    end else if (rx_valid && rx_data == CH_CLOSE) begin
      nxt_lock = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      lock_ff <= 1'b0;
      src_ff <= 1'b0;
    end else begin
      lock_ff <= nxt_lock;
      src_ff <= nxt_src;
    end
  end

  // ----------------------------------------------------------------
  // Command framing and alarms
  // ----------------------------------------------------------------
  logic cmd_valid;
  rar_cmd_t cmd;

  rar_frame #(.DEPTH(CMD_BUF_DEPTH)) u_frame (
    .clock(clock),
    .sys_rst(sys_rst),
    .byte_valid(rx_valid),
    .byte_data(rx_data),
    .cmd_valid(cmd_valid),
    .cmd(cmd)
  );

  logic [1:0][DIST_W-1:0] thr_v;
  logic [1:0][ANGLE_W-1:0] lo_v, hi_v;
  logic [1:0] alarm_v;

  assign thr_v = {alarm_b_thresh, alarm_a_thresh};
  assign lo_v = {zone_b_lo, zone_a_lo};
  assign hi_v = {zone_b_hi, zone_a_hi};

  for (genvar i = 0; i < 2; i++) begin : g_alarm
    rar_alarm #(.DIST_W(DIST_W), .ANGLE_W(ANGLE_W)) u_alarm (
      .clock(clock),
      .sys_rst(sys_rst),
      .meas_valid(meas_valid),
      .meas_dist(dist_median),
      .scan_on(scan_on),
      .scan_angle(scan_angle),
      .sweep_end(sweep_end),
      .thresh(thr_v[i]),
      .hyst(alarm_hyst),
      .zone_lo(lo_v[i]),
      .zone_hi(hi_v[i]),
      .alarm(alarm_v[i])
    );
  end

  assign alarm_a = alarm_v[0];
  assign alarm_b = alarm_v[1];

  // ----------------------------------------------------------------
  // Reply generator
  // ----------------------------------------------------------------
  rar_rpl_t st_ff, nxt_st;
  logic kind_ff, nxt_kind, sel_ff, nxt_sel;
  logic [4:0] pos_ff, nxt_pos, last;
  logic [16:0] rem_ff, nxt_rem;
  logic [2:0] cidx_ff, nxt_cidx;
  logic [5:0][3:0] dig_ff, nxt_dig;
  logic tx_valid_ff, nxt_tx_valid, tx_i2c_ff, nxt_tx_i2c, tx_free, skip;
  logic [7:0] tx_data_ff, nxt_tx_data, ch;
  logic [3:0] lz;
  logic is_dist, is_raw;

  // Character at the current reply position; leading metre zeros skip
  always_comb begin
    lz[0] = dig_ff[0] == 4'h0;
    for (int k = 1; k < 4; k++) begin
      lz[k] = lz[k-1] && dig_ff[k] == 4'h0;
    end
    ch = CH_LF;
    skip = 1'b0;
    last = kind_ff ? 5'(DIST_REPLY_LAST) : 5'(ID_LEN + 1);
    if (!kind_ff) begin
      if (pos_ff < 5'(ID_LEN)) begin
        ch = ID_TEXT[8*(ID_LEN-1-int'(pos_ff)) +: 8];
      end else if (pos_ff == 5'(ID_LEN)) begin
        ch = CH_CR;
      end
    end else begin
      case (pos_ff)
        5'h00: ch = CH_TAG_1;
        5'h01: ch = CH_TAG_2;
        5'h02: ch = CH_TAG_3;
        5'h03: ch = CH_COMMA;
        5'h04: ch = sel_ff ? CH_ONE : CH_ZERO;
        5'h05: ch = CH_COLON;
        5'h06, 5'h07, 5'h08, 5'h09: begin
          ch = CH_ZERO | {4'h0, dig_ff[3'(pos_ff - 5'h06)]};
          skip = pos_ff != 5'h09 && lz[2'(pos_ff - 5'h06)];
        end
        5'h0a: ch = CH_DOT;
        5'h0b: ch = CH_ZERO | {4'h0, dig_ff[4]};
        5'h0c: ch = CH_ZERO | {4'h0, dig_ff[5]};
        5'h0d: ch = CH_CR;
        default: ch = CH_LF;
      endcase
    end
  end

  always_comb begin
    is_dist = cmd == RAR_CMD_FIRST_MED || cmd == RAR_CMD_FIRST_RAW;
    is_raw = cmd == RAR_CMD_FIRST_RAW;
    tx_free = !tx_valid_ff || tx_ready;
    nxt_st = st_ff;
    nxt_kind = kind_ff;
    nxt_sel = sel_ff;
    nxt_pos = pos_ff;
    nxt_rem = rem_ff;
    nxt_cidx = cidx_ff;
    nxt_dig = dig_ff;
    nxt_tx_valid = tx_valid_ff && !tx_ready;
    nxt_tx_data = tx_data_ff;
    nxt_tx_i2c = tx_i2c_ff;
    case (st_ff)
      RPL_IDLE: begin
        if (cmd_valid) begin
          nxt_pos = 5'h00;
          nxt_cidx = 3'h0;
          nxt_dig = '0;
          nxt_tx_i2c = src_ff;
          nxt_kind = is_dist;
          nxt_sel = is_raw;
          nxt_rem = 17'(is_raw ? dist_raw : dist_median);
          nxt_st = is_dist ? RPL_CONV : RPL_EMIT;
        end
      end
      RPL_CONV: begin
        if (rem_ff >= rar_weight(cidx_ff)) begin
          nxt_rem = rem_ff - rar_weight(cidx_ff);
          nxt_dig[cidx_ff] = dig_ff[cidx_ff] + 4'h1;
        end else if (cidx_ff == 3'h5) begin
          nxt_st = RPL_EMIT;
        end else begin
          nxt_cidx = cidx_ff + 3'h1;
        end
      end
      RPL_EMIT: begin
        if (tx_free) begin
          if (!skip) begin
            nxt_tx_valid = 1'b1;
            nxt_tx_data = ch;
          end
          nxt_pos = pos_ff + 5'h01;
          if (pos_ff == last) begin
            nxt_st = RPL_DRAIN;
          end
        end
      end
      RPL_DRAIN: begin
        if (tx_free) begin
          nxt_st = RPL_IDLE;
        end
      end
      default: nxt_st = RPL_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      st_ff <= RPL_IDLE;
      kind_ff <= 1'b0;
      sel_ff <= 1'b0;
      pos_ff <= 5'h00;
      rem_ff <= 17'h00000;
      cidx_ff <= 3'h0;
      dig_ff <= '0;
      tx_valid_ff <= 1'b0;
      tx_data_ff <= 8'h00;
      tx_i2c_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      kind_ff <= nxt_kind;
      sel_ff <= nxt_sel;
      pos_ff <= nxt_pos;
      rem_ff <= nxt_rem;
      cidx_ff <= nxt_cidx;
      dig_ff <= nxt_dig;
      tx_valid_ff <= nxt_tx_valid;
      tx_data_ff <= nxt_tx_data;
      tx_i2c_ff <= nxt_tx_i2c;
    end
  end

  assign tx_valid = tx_valid_ff;
  assign tx_data = tx_data_ff;
  assign tx_to_i2c = tx_i2c_ff;

  // ----------------------------------------------------------------
  // I2C target address
  // ----------------------------------------------------------------
  logic [6:0] addr_ff, nxt_addr;
  logic match_ff, nxt_match;

  always_comb begin
    nxt_addr = i2c_addr_wr ? i2c_addr_new : addr_ff;
    nxt_match = i2c_addr_seen_valid && i2c_addr_seen == addr_ff;
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      addr_ff <= I2C_ADDR_RST;
      match_ff <= 1'b0;
    end else begin
      addr_ff <= nxt_addr;
      match_ff <= nxt_match;
    end
  end

  assign i2c_addr = addr_ff;
  assign i2c_addr_match = match_ff;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_dist_cmd;
    st_ff == RPL_IDLE && cmd_valid && (cmd == RAR_CMD_FIRST_MED || cmd == RAR_CMD_FIRST_RAW);
  endsequence
  sequence s_id_cmd;
    st_ff == RPL_IDLE && cmd_valid && (cmd == RAR_CMD_PRODUCT || cmd == RAR_CMD_SYNC);
  endsequence

  a_dist_reply: assert property (@(posedge clock) disable iff (sys_rst)
    s_dist_cmd |-> ##[1:80] (tx_valid_ff && tx_data_ff == CH_TAG_1))
    else $error("distance reply did not start with tag");
  a_id_reply: assert property (@(posedge clock) disable iff (sys_rst)
    s_id_cmd |-> ##2 (tx_valid_ff && tx_data_ff == ID_TEXT[8*(ID_LEN-1) +: 8]))
    else $error("identity reply did not start with identity text");
  a_tx_hold: assert property (@(posedge clock) disable iff (sys_rst)
    (tx_valid_ff && !tx_ready) |=> (tx_valid_ff && $stable(tx_data_ff) && $stable(tx_i2c_ff)))
    else $error("reply byte dropped while stalled");
  a_addr_match: assert property (@(posedge clock) disable iff (sys_rst)
    (i2c_addr_seen_valid && i2c_addr_seen == addr_ff) |=> match_ff)
    else $error("own I2C address not matched");
endmodule : rar_top
`default_nettype wire

// *** testbench/rar_host_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module rar_host_model (
  input wire logic clock,
  input wire logic slow,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_to_i2c,
  output logic ser_rx_valid,
  output logic [7:0] ser_rx_data,
  output logic i2c_rx_valid,
  output logic [7:0] i2c_rx_data,
  output logic tx_ready
);
  logic [7:0] rx_q[$];
  logic last_i2c;
  logic [1:0] stall_ff;

  initial begin
    ser_rx_valid = 1'b0;
    ser_rx_data = 8'h00;
    i2c_rx_valid = 1'b0;
    i2c_rx_data = 8'h00;
    tx_ready = 1'b1;
    stall_ff = 2'h0;
    last_i2c = 1'b0;
  end

  // ----------------------------------------
  // Reply capture, ready only one cycle in four when slow
  // ----------------------------------------
  always @(posedge clock) begin
    stall_ff <= stall_ff + 2'h1;
    tx_ready <= !slow || (stall_ff == 2'h3);
    if (tx_valid && tx_ready) begin
      rx_q.push_back(tx_data);
      last_i2c <= tx_to_i2c;
    end
  end

  // ----------------------------------------
  // Byte sender on either port; idle data on the sending port shows the inverse of its last byte, the other port's data toggles
  // ----------------------------------------
  task automatic send(input string s, input bit i2c);
    for (int i = 0; i < s.len(); i++) begin
      @(posedge clock);
      if (i2c) begin
        i2c_rx_valid <= 1'b1;
        i2c_rx_data <= s[i];
      end else begin
        ser_rx_valid <= 1'b1;
        ser_rx_data <= s[i];
      end
    end
    @(posedge clock);
    ser_rx_valid <= 1'b0;
    i2c_rx_valid <= 1'b0;
    ser_rx_data <= ~ser_rx_data;
    i2c_rx_data <= ~i2c_rx_data;
  endtask : send
endmodule : rar_host_model
`default_nettype wire

// *** testbench/rar_top_bench.sv ***
`timescale 1ns/1ns
`default_nettype none
`define RAR_CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin fails++; \
  $display("MISMATCH at %0t: got %0h expected %0h", $time, got, exp); end end
module rar_top_bench import rar_pkg::*;;
  // Arbitrary identity text
  localparam logic [8*ID_MAX-1:0] ID = "p:QX07,2.3.4,5";
  localparam int IDL = 14;
  int fails = 0;
  int num_checks = 0;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic meas_valid = 1'b0, scan_on = 1'b0, sweep_end = 1'b0, slow = 1'b0;
  logic addr_wr = 1'b0, seen_v = 1'b0;
  logic [6:0] addr_new = 7'h00, seen = 7'h00, i2c_addr;
  logic [16:0] dist_median = 17'h0, dist_raw = 17'h0, thr_a = 17'h3e8, thr_b = 17'h1f4, hyst = 17'h064;
  logic [9:0] angle = 10'h0, za_lo = 10'h064, za_hi = 10'h0c8, zb_lo = 10'h0fa, zb_hi = 10'h15e;
  logic ser_v, i2c_v, tx_ready, alarm_a, alarm_b, tx_valid, tx_to_i2c, addr_match;
  logic [7:0] ser_d, i2c_d, tx_data;
  logic [16:0] d_tab[7] = '{17'h3b6, 17'h383, 17'h41a, 17'h44c, 17'h18f, 17'h257, 17'h258};
  logic [6:0] ea_tab = 7'h76;
  logic [6:0] eb_tab = 7'h30;

  always #4 clock = ~clock;

  rar_top #(.ID_LEN(IDL), .ID_TEXT(ID)) i_dut (.clock(clock), .sys_rst(sys_rst), .meas_valid(meas_valid),
    .dist_median(dist_median), .dist_raw(dist_raw), .scan_on(scan_on), .scan_angle(angle),
    .sweep_end(sweep_end), .alarm_a_thresh(thr_a), .alarm_b_thresh(thr_b), .alarm_hyst(hyst),
    .zone_a_lo(za_lo), .zone_a_hi(za_hi), .zone_b_lo(zb_lo), .zone_b_hi(zb_hi),
    .ser_rx_valid(ser_v), .ser_rx_data(ser_d), .i2c_rx_valid(i2c_v), .i2c_rx_data(i2c_d),
    .i2c_addr_wr(addr_wr), .i2c_addr_new(addr_new), .i2c_addr_seen_valid(seen_v),
    .i2c_addr_seen(seen), .tx_ready(tx_ready), .alarm_a(alarm_a), .alarm_b(alarm_b),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_to_i2c(tx_to_i2c), .i2c_addr(i2c_addr),
    .i2c_addr_match(addr_match));

  rar_host_model i_host (.clock(clock), .slow(slow), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_to_i2c(tx_to_i2c), .ser_rx_valid(ser_v), .ser_rx_data(ser_d), .i2c_rx_valid(i2c_v),
    .i2c_rx_data(i2c_d), .tx_ready(tx_ready));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic string id_str();
    string s;
    s = "";
    for (int i = IDL - 1; i >= 0; i--) s = $sformatf("%s%c", s, ID[8*i +: 8]);
    return $sformatf("%s%c%c", s, CH_CR, CH_LF);
  endfunction : id_str

  function automatic string dstr(input logic [7:0] sel, input int cm);
    return $sformatf("%c%c%c,%c:%0d.%02d%c%c", CH_TAG_1, CH_TAG_2, CH_TAG_3, sel, cm / 100, cm % 100,
      CH_CR, CH_LF);
  endfunction : dstr

  // Distance query frame with the given selector text
  function automatic string dq(input string sel);
    return $sformatf("<%c%c%c%c,%s>", CH_QUERY, CH_FQ_1, CH_FQ_2, CH_FQ_3, sel);
  endfunction : dq

  task automatic query(input string cmd, input bit i2c, input string exp);
    string r;
    int n;
    r = "";
    n = 0;
    i_host.rx_q.delete();
    i_host.send(cmd, i2c);
    while (n < 400 && !(i_host.rx_q.size() > 0 && i_host.rx_q[$] == CH_LF)) begin
      @(posedge clock);
      n++;
    end
    #1;
    foreach (i_host.rx_q[k]) r = $sformatf("%s%c", r, i_host.rx_q[k]);
    `RAR_CHK(r == exp, 1'b1)
    `RAR_CHK(i_host.last_i2c, i2c)
    `RAR_CHK(tx_valid, 1'b0)
    repeat (4) @(posedge clock);
  endtask : query

  task automatic meas(input logic [16:0] d, input logic [9:0] a);
    @(posedge clock);
    meas_valid <= 1'b1;
    dist_median <= d;
    angle <= a;
    @(posedge clock);
    meas_valid <= 1'b0;
    repeat (2) @(posedge clock);
  endtask : meas

  task automatic sweep();
    @(posedge clock);
    sweep_end <= 1'b1;
    @(posedge clock);
    sweep_end <= 1'b0;
    repeat (2) @(posedge clock);
  endtask : sweep

  task automatic chk_al(input logic a, input logic b);
    `RAR_CHK(alarm_a, a)
    `RAR_CHK(alarm_b, b)
  endtask : chk_al

  task automatic see(input logic [6:0] a, input logic m);
    @(posedge clock);
    seen_v <= 1'b1;
    seen <= a;
    @(posedge clock);
    seen_v <= 1'b0;
    #1;
    `RAR_CHK(addr_match, m)
  endtask : see

  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : test_done

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    repeat (4) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    #1;
    chk_al(1'b0, 1'b0);
    `RAR_CHK(tx_valid, 1'b0)
    `RAR_CHK(i2c_addr, 7'h66)
    see(7'h66, 1'b1);
    see(7'h65, 1'b0);
    query("<?>", 1'b0, id_str());
    slow <= 1'b1;
    query($sformatf("<%c%c>", CH_SYNC, CH_SYNC), 1'b1, id_str());
    slow <= 1'b0;
    dist_median <= 17'h246;
    dist_raw <= 17'h247;
    query(dq("0"), 1'b1, dstr(CH_ZERO, 17'h246));
    query(dq("1"), 1'b0, dstr(CH_ONE, 17'h247));
    dist_median <= 17'h007;
    dist_raw <= 17'h2710;
    query(dq("0"), 1'b0, dstr(CH_ZERO, 17'h007));
    query(dq("1"), 1'b1, dstr(CH_ONE, 17'h2710));
    i_host.rx_q.delete();
    i_host.send("?>", 1'b0);
    i_host.send("<?LDX,0>", 1'b1);
    i_host.send(dq("2"), 1'b0);
    repeat (80) @(posedge clock);
    `RAR_CHK(i_host.rx_q.size() == 0, 1'b1)
    chk_al(1'b0, 1'b0);
    @(posedge clock);
    addr_wr <= 1'b1;
    addr_new <= 7'h12;
    @(posedge clock);
    addr_wr <= 1'b0;
    see(7'h12, 1'b1);
    `RAR_CHK(i2c_addr, 7'h12)
    see(7'h66, 1'b0);
    for (int i = 0; i < 7; i++) begin
      meas(d_tab[i], 10'h000);
      chk_al(ea_tab[i], eb_tab[i]);
    end
    hyst <= 17'h0;
    thr_a <= 17'h1ffff;
    meas(17'h2710, 10'h000);
    chk_al(1'b0, 1'b0);
    hyst <= 17'h1ffff;
    meas(17'h2327, 10'h000);
    chk_al(1'b1, 1'b0);
    meas(17'h2af8, 10'h000);
    chk_al(1'b0, 1'b0);
    thr_a <= 17'h3e8;
    scan_on <= 1'b1;
    meas(17'h1f4, 10'h096);
    chk_al(1'b0, 1'b0);
    meas(17'h064, 10'h12c);
    chk_al(1'b0, 1'b0);
    sweep();
    chk_al(1'b1, 1'b1);
    meas(17'h064, 10'h0c9);
    meas(17'h1c2, 10'h0fa);
    chk_al(1'b1, 1'b1);
    sweep();
    chk_al(1'b0, 1'b1);
    meas(17'h3e7, 10'h0c8);
    sweep();
    chk_al(1'b1, 1'b0);
    scan_on <= 1'b0;
    test_done();
  end

  initial begin
    repeat (20000) @(posedge clock);
    fails++;
    test_done();
  end
endmodule : rar_top_bench
`default_nettype wire
